// ==== nts_store_combine.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "nts_store_regs.svh"
// Summary of operation
// - stores to one line combine, full line writes
// - repeated bytes keep only latest value
// - buffered stores may retire in any order
// - bypass caches, never read for ownership
// - fence drains all combined data to memory
// - uncacheable/write-protect regions: plain uncached store
// - write-combining region keeps combining semantics
// - cached hit kept consistent: merge or evict
// - mixed policy: first-level hit merges in place
// - mixed policy: second-level hit written out, removed
// - cacheable miss: weakly ordered, combined, no allocate
// - write-back region accepted, store type overrides
// - bus type is first store's type
// - in-place updated line survives a fence
// - evict-only: store writes cached copy out
// - packed single: 16 bytes, misaligned faults
// - masked store: byte written if mask bit7
// - fence holds later stores until drained
module nts_store_combine import nts_pkg::*; (
	// clock and reset
	input  wire logic                       clock,
	input  wire logic                       rst_n,
	// store request from the core
	input  wire logic                       st_valid,
	output logic                            st_ready,
	input  wire logic [31:0]                st_addr,
	input  wire logic [`NTS_OP_BITS-1:0]    st_data,
	input  wire logic [`NTS_OP_BITS-1:0]    st_mask,
	input  wire nts_kind_t                  st_kind,
	input  wire nts_mtype_t                 st_mtype,
	// cache lookup result for the store line
	input  wire logic                       st_l1_hit,
	input  wire logic                       st_l2_hit,
	input  wire logic [`NTS_LINE_BITS-1:0]  hit_line_data,
	// policy strap, high selects mixed merge/evict handling
	input  wire logic                       mixed_policy,
	// exception to the core
	output logic                            gp_fault,
	// store fence handshake
	input  wire logic                       fence_req,
	output logic                            fence_ack,
	// first-level in-place merge
	output logic                            l1_wr_valid,
	output logic [`NTS_LINE_AW-1:0]         l1_wr_line,
	output logic [`NTS_LINE_BITS-1:0]       l1_wr_data,
	output logic [`NTS_LINE_BYTES-1:0]      l1_wr_be,
	// cache line removal
	output logic                            cache_evict,
	output logic [`NTS_LINE_AW-1:0]         evict_line,
	// system bus write
	output logic                            bus_valid,
	input  wire logic                       bus_ready,
	output logic [`NTS_LINE_AW-1:0]         bus_line,
	output logic [`NTS_LINE_BITS-1:0]       bus_data,
	output logic [`NTS_LINE_BYTES-1:0]      bus_be,
	output nts_mtype_t                      bus_mtype
);
	////////////////////////////////////////////////////////////////////////////////
	// reset release
	logic rst_meta_n; // first stage, read only by the second
	logic rst_sync_n; // design-wide reset
	// asynchronous assert, two-flop release
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state
	nts_state_t                 state;     // drain sequencer
	logic                       buf_valid; // combining buffer holds data
	logic [`NTS_LINE_AW-1:0]    buf_line;  // line held by the buffer
	logic [`NTS_LINE_BYTES-1:0] buf_be;    // bytes written so far
	nts_mtype_t                 buf_mtype; // type of first store to the line
	nts_buf_if                  mem_if ();  // storage port

	////////////////////////////////////////////////////////////////////////////////
	// store decode
	logic [`NTS_OFS_BITS-1:0]   st_ofs;      // byte offset in line
	logic [`NTS_LINE_AW-1:0]    st_line;     // line address
	logic [`NTS_OP_BYTES-1:0]   mask_bit7;   // mask operand byte sign bits
	logic [`NTS_OP_BYTES-1:0]   op_be;       // operand byte enables
	logic [`NTS_LINE_BYTES-1:0] st_be;       // enables placed in line
	logic [`NTS_LINE_BITS-1:0]  st_line_data; // data placed in line
	logic [`NTS_LINE_BITS-1:0]  merged_line; // hit line merged with store
	logic                       misaligned;  // packed single off 16 bytes
	logic                       do_unc;      // plain uncached store
	logic                       do_l1;       // merge into first level
	logic                       do_evict;    // write line out and remove
	logic                       do_comb;     // combine in buffer
	logic                       conflict;    // buffer holds another line
	logic                       take;        // store accepted this cycle
	logic                       drain_start; // buffer must go to the bus

	assign st_ofs  = st_addr[`NTS_OFS_BITS-1:0];
	assign st_line = st_addr[31:`NTS_OFS_BITS];

	// mask bit 7 of each byte of the mask operand
	for (genvar i = 0; i < `NTS_OP_BYTES; i++) begin : g_mask
		assign mask_bit7[i] = st_mask[8*i + 7];
	end

	// operand width per variant; masked forms also gate by mask bit 7
	always_comb begin
		case (st_kind)
			stream_store_quadword:   op_be = `NTS_BE_8B;
			stream_store_integer:    op_be = `NTS_BE_4B;
			masked_stream_store_64:  op_be = `NTS_BE_8B & mask_bit7[7:0];
			masked_stream_store_128: op_be = `NTS_BE_16B & mask_bit7;
			default:                 op_be = `NTS_BE_16B;
		endcase
	end

	// place operand in the line; stores are assumed not to split lines
	assign st_be        = `NTS_LINE_BYTES'(op_be) << st_ofs;
	assign st_line_data = `NTS_LINE_BITS'(st_data) << {st_ofs, 3'b000};

	// hit line with store bytes laid over it
	for (genvar i = 0; i < `NTS_LINE_BYTES; i++) begin : g_merge
		assign merged_line[8*i +: 8] = st_be[i] ? st_line_data[8*i +: 8]
		                                        : hit_line_data[8*i +: 8];
	end

	// only the packed single form checks 16-byte alignment
	assign misaligned = (st_kind == stream_store_packed_single)
	                 && (st_addr[3:0] != `NTS_ALIGN16_OK);

	// path selection by region type and cache residency
	always_comb begin
		do_unc   = 1'b0;
		do_l1    = 1'b0;
		do_evict = 1'b0;
		do_comb  = 1'b0;
		case (st_mtype)
			uncacheable_type, write_protect_type: do_unc = 1'b1;
			write_through_type, write_back_type: begin
				if (mixed_policy && st_l1_hit) begin
					do_l1 = 1'b1;
				end else if (st_l1_hit || st_l2_hit) begin
					do_evict = 1'b1;
				end else begin
					do_comb = 1'b1;
				end
			end
			default: do_comb = 1'b1;
		endcase
	end

	assign conflict = buf_valid && (st_line != buf_line);

	// stores wait behind a fence, a pending bus write or a needed drain
	assign st_ready = (state == S_IDLE) && !bus_valid && !fence_req
	               && !(&buf_be) && !(do_comb && conflict);
	assign take     = st_valid && st_ready;

	// full line, fence, or a combining store to another line forces the buffer out
	assign drain_start = (state == S_IDLE) && !bus_valid && buf_valid
	                  && ((&buf_be) || fence_req
	                  || (st_valid && do_comb && conflict));

	// fence completes once nothing combined or issued remains
	assign fence_ack = fence_req && (state == S_IDLE)
	                && !buf_valid && !bus_valid;

	////////////////////////////////////////////////////////////////////////////////
	// storage
	assign mem_if.wr_en   = take && !misaligned && do_comb;
	assign mem_if.wr_be   = st_be;
	assign mem_if.wr_data = st_line_data;

	nts_line_mem u_line_mem (
		.clock (clock),
		.port  (mem_if)
	);

	////////////////////////////////////////////////////////////////////////////////
	// drain sequencer: two cycles let the registered storage read settle
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state <= S_IDLE;
		end else begin
			case (state)
				S_IDLE:   if (drain_start) state <= S_SETTLE;
				S_SETTLE: state <= S_LOAD;
				S_LOAD:   state <= S_IDLE;
				default:  state <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// combining buffer bookkeeping
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			buf_valid <= 1'b0;
			buf_line  <= `NTS_LINE_NONE;
			buf_be    <= `NTS_BE_NONE;
			buf_mtype <= write_combining_type;
		end else if (state == S_LOAD) begin
			// contents copied to the bus register, buffer free again
			buf_valid <= 1'b0;
			buf_be    <= `NTS_BE_NONE;
		end else if (mem_if.wr_en) begin
			buf_valid <= 1'b1;
			if (!buf_valid) begin
				// first store opens the line and fixes its bus type
				buf_line  <= st_line;
				buf_mtype <= st_mtype;
				buf_be    <= st_be;
			end else begin
				buf_be <= buf_be | st_be;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// bus write register; writes only, so no ownership read is ever made
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			bus_valid <= 1'b0;
			bus_line  <= `NTS_LINE_NONE;
			bus_data  <= '0;
			bus_be    <= `NTS_BE_NONE;
			bus_mtype <= write_combining_type;
		end else if (bus_valid) begin
			// hold until the bus takes it
			if (bus_ready) bus_valid <= 1'b0;
		end else if (state == S_LOAD) begin
			bus_valid <= 1'b1;
			bus_line  <= buf_line;
			bus_data  <= mem_if.rd_data;
			bus_be    <= buf_be;
			bus_mtype <= buf_mtype;
		end else if (take && !misaligned && do_unc) begin
			bus_valid <= 1'b1;
			bus_line  <= st_line;
			bus_data  <= st_line_data;
			bus_be    <= st_be;
			bus_mtype <= st_mtype;
		end else if (take && !misaligned && do_evict) begin
			// whole line out so non-coherent readers see current data
			bus_valid <= 1'b1;
			bus_line  <= st_line;
			bus_data  <= merged_line;
			bus_be    <= ~`NTS_BE_NONE;
			bus_mtype <= st_mtype;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// cache side effects; a merged first-level line is never touched by a fence
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			l1_wr_valid <= 1'b0;
			l1_wr_line  <= `NTS_LINE_NONE;
			l1_wr_data  <= '0;
			l1_wr_be    <= `NTS_BE_NONE;
			cache_evict <= 1'b0;
			evict_line  <= `NTS_LINE_NONE;
		end else begin
			l1_wr_valid <= take && !misaligned && do_l1;
			cache_evict <= take && !misaligned && do_evict;
			if (take && do_l1) begin
				l1_wr_line <= st_line;
				l1_wr_data <= st_line_data;
				l1_wr_be   <= st_be;
			end
			if (take && do_evict) evict_line <= st_line;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// alignment exception pulse; the faulting store writes nothing
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			gp_fault <= 1'b0;
		end else begin
			gp_fault <= take && misaligned;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	sequence full_buffer_s;
		(state == S_IDLE) && !bus_valid && buf_valid && (&buf_be);
	endsequence
	sequence drain_out_s;
		(state == S_SETTLE) ##1 (state == S_LOAD) ##1 (bus_valid && (&bus_be));
	endsequence

	full_line_drain_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
		full_buffer_s |=> drain_out_s)
		else $error("full line not written to the bus");

	align_fault_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
		(take && misaligned) |=> (gp_fault && !l1_wr_valid && !cache_evict))
		else $error("misaligned packed store did not fault");

	uncached_path_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
		(take && !misaligned && do_unc) |=>
		(bus_valid && bus_mtype == $past(st_mtype) && bus_be == $past(st_be)))
		else $error("uncached store not issued with its own type");

	evict_path_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
		(take && !misaligned && do_evict) |=>
		(cache_evict && bus_valid && (&bus_be) && evict_line == bus_line))
		else $error("hit line not written out and removed");

	l1_merge_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
		l1_wr_valid |-> $past(take && mixed_policy && st_l1_hit && !bus_valid))
		else $error("in-place merge without a first-level hit");

	fence_drain_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
		(fence_req && buf_valid && state == S_IDLE && !bus_valid) |=>
		(!fence_ack) [*3] ##1 bus_valid)
		else $error("fence did not drain the buffer");

	fence_hold_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
		(fence_req && !fence_ack) |-> !st_ready)
		else $error("store passed an open fence");

	partial_drain_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
		(state == S_LOAD && !bus_valid) |=>
		(bus_valid && bus_be == $past(buf_be) && bus_mtype == $past(buf_mtype)))
		else $error("drain enables or type wrong");
endmodule // nts_store_combine
`default_nettype wire

// ==== nts_store_regs.svh ====
`ifndef NTS_STORE_REGS_SVH
`define NTS_STORE_REGS_SVH
// line geometry
`define NTS_LINE_BYTES   64
`define NTS_LINE_BITS    512
`define NTS_OFS_BITS     6
`define NTS_LINE_AW      26
// store operand geometry
`define NTS_OP_BYTES     16
`define NTS_OP_BITS      128
// byte enables per store width, low lanes of a 16-byte operand
`define NTS_BE_16B       16'hffff
`define NTS_BE_8B        16'h00ff
`define NTS_BE_4B        16'h000f
// alignment check for the 16-byte packed store
`define NTS_ALIGN16_OK   4'h0
// reset values
`define NTS_BE_NONE      64'h0000_0000_0000_0000
`define NTS_LINE_NONE    26'h000_0000
`endif

// ==== nts_pkg.sv ====
`default_nettype none
package nts_pkg;
	// store variants issued by the core
	typedef enum logic [2:0] {
		stream_store_packed_single,
		stream_store_packed_double,
		stream_store_quadword,
		stream_store_double_quadword,
		stream_store_integer,
		masked_stream_store_64,
		masked_stream_store_128
	} nts_kind_t;
	// region memory type
	typedef enum logic [2:0] {
		uncacheable_type,
		write_protect_type,
		write_combining_type,
		write_through_type,
		write_back_type
	} nts_mtype_t;
	// drain sequencer
	typedef enum logic [1:0] {
		S_IDLE,
		S_SETTLE,
		S_LOAD
	} nts_state_t;
endpackage
`default_nettype wire

// ==== nts_buf_if.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "nts_store_regs.svh"
// combining line storage port
interface nts_buf_if;
	logic                      wr_en;   // byte write strobe
	logic [`NTS_LINE_BYTES-1:0] wr_be;   // bytes to update
	logic [`NTS_LINE_BITS-1:0]  wr_data; // line-aligned data
	logic [`NTS_LINE_BITS-1:0]  rd_data; // registered line image
	modport ctrl (output wr_en, output wr_be, output wr_data, input rd_data);
	modport mem  (input wr_en, input wr_be, input wr_data, output rd_data);
endinterface // nts_buf_if
`default_nettype wire

// ==== nts_line_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "nts_store_regs.svh"
module nts_line_mem (
	// clock
	input wire logic clock,
	// storage port
	nts_buf_if.mem   port
);
	logic [7:0] line [`NTS_LINE_BYTES]; // one line of bytes, no reset needed

	// per-byte write; a later write simply overwrites, so only the last value stays
	for (genvar i = 0; i < `NTS_LINE_BYTES; i++) begin : g_byte
		always_ff @(posedge clock) begin
			if (port.wr_en && port.wr_be[i]) begin
				line[i] <= port.wr_data[8*i +: 8];
			end
			port.rd_data[8*i +: 8] <= line[i];
		end
	end
endmodule // nts_line_mem
`default_nettype wire

// ==== nts_bus_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// system bus agent: accepts line writes, stalls on request
module nts_bus_model (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst_n,
	// write channel
	input  wire logic bus_valid,
	output logic      bus_ready,
	// stall from the bench
	input  wire logic stall
);
	// ready only toward an offered write; no read path exists here,
	// so an ownership read would simply never be answered
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bus_ready <= 1'b0;
		end else begin
			bus_ready <= bus_valid && !stall;
		end
	end
endmodule // nts_bus_model
`default_nettype wire

// ==== nts_store_combine_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module nts_store_combine_tb;
	import nts_pkg::*;
	// one expected event: 0 bus write, 1 l1 merge, 2 evict, 3 fault
	typedef struct {
		logic [1:0]   ev;
		logic [25:0]  line;
		logic [511:0] data;
		logic [63:0]  be;
		nts_mtype_t   mt;
		logic         mtc;
	} nts_exp_t;
	logic clock, rst_n, st_valid, st_ready, st_l1_hit, st_l2_hit, mixed_policy, gp_fault;
	logic fence_req, fence_ack, l1_wr_valid, cache_evict, bus_valid, bus_ready, stall;
	logic [31:0] st_addr;
	logic [127:0] st_data, st_mask;
	nts_kind_t st_kind;
	nts_mtype_t st_mtype, bus_mtype;
	logic [511:0] hit_line_data, l1_wr_data, bus_data;
	logic [25:0] l1_wr_line, evict_line, bus_line;
	logic [63:0] l1_wr_be, bus_be;
	int errors, tests_run, seed;
	logic take_n, ack_n;
	nts_exp_t expq[$];
	// bench copy of the combining buffer
	logic cv;
	logic [25:0] cl;
	logic [511:0] cd;
	logic [63:0] cb;
	nts_mtype_t cm;

	nts_store_combine u_dut (.clock(clock), .rst_n(rst_n), .st_valid(st_valid),
		.st_ready(st_ready), .st_addr(st_addr), .st_data(st_data), .st_mask(st_mask),
		.st_kind(st_kind), .st_mtype(st_mtype), .st_l1_hit(st_l1_hit),
		.st_l2_hit(st_l2_hit), .hit_line_data(hit_line_data), .mixed_policy(mixed_policy),
		.gp_fault(gp_fault), .fence_req(fence_req), .fence_ack(fence_ack),
		.l1_wr_valid(l1_wr_valid), .l1_wr_line(l1_wr_line), .l1_wr_data(l1_wr_data),
		.l1_wr_be(l1_wr_be), .cache_evict(cache_evict), .evict_line(evict_line),
		.bus_valid(bus_valid), .bus_ready(bus_ready), .bus_line(bus_line),
		.bus_data(bus_data), .bus_be(bus_be), .bus_mtype(bus_mtype));
	nts_bus_model u_bus (.clock(clock), .rst_n(rst_n), .bus_valid(bus_valid),
		.bus_ready(bus_ready), .stall(stall));

	initial begin
		clock = 0;
		forever #2.5 clock = ~clock;
	end
	// bus stalls about one cycle in four
	always @(posedge clock) stall <= ($random(seed) & 3) == 0;
	// handshakes sampled mid-cycle, settled before the taking edge
	always @(negedge clock) begin
		take_n <= st_valid && st_ready;
		ack_n <= fence_req && fence_ack;
	end

	function automatic logic [511:0] spread(input logic [63:0] be);
		for (int i = 0; i < 64; i++) spread[8*i +: 8] = {8{be[i]}};
	endfunction

	task automatic check(input logic [511:0] seen, input logic [511:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic pop_cmp(input logic [1:0] ev, input logic [25:0] ln,
		input logic [511:0] d, input logic [63:0] be, input nts_mtype_t mt);
		nts_exp_t e;
		if (expq.size() == 0) begin
			check(ev, 4);
			return;
		end
		e = expq.pop_front();
		check(ev, e.ev);
		check(ln, e.line);
		check(be, e.be);
		check(d & spread(be), e.data & spread(e.be));
		if (e.mtc) check(mt, e.mt);
	endtask

	// every visible result is matched against the oldest note
	always @(negedge clock) begin
		if (rst_n) begin
			if (cache_evict) pop_cmp(2'd2, evict_line, '0, '0, bus_mtype);
			if (bus_valid && bus_ready) pop_cmp(2'd0, bus_line, bus_data, bus_be, bus_mtype);
			if (l1_wr_valid) pop_cmp(2'd1, l1_wr_line, l1_wr_data, l1_wr_be, bus_mtype);
			if (gp_fault) pop_cmp(2'd3, '0, '0, '0, bus_mtype);
		end
	end

	task automatic drain();
		expq.push_back('{2'd0, cl, cd, cb, cm, 1'b1});
		cv = 0;
		cb = '0;
		cd = '0;
	endtask

	task automatic store(input logic [31:0] a, input nts_kind_t k, input nts_mtype_t mt,
		input logic l1, input logic l2);
		logic [127:0] dat, m;
		logic [511:0] d, h;
		logic [63:0] be;
		logic [15:0] b;
		nts_exp_t e;
		dat = {$random(seed), $random(seed), $random(seed), $random(seed)};
		m = {$random(seed), $random(seed), $random(seed), $random(seed)} | 128'h80;
		for (int i = 0; i < 16; i++) h[32*i +: 32] = $random(seed);
		b = (k == stream_store_integer) ? 16'h000f :
			(k == stream_store_quadword || k == masked_stream_store_64) ? 16'h00ff : 16'hffff;
		if (k == masked_stream_store_64 || k == masked_stream_store_128)
			for (int i = 0; i < 16; i++) b[i] &= m[8*i+7];
		be = 64'(b) << a[5:0];
		// only enabled bytes belong to the store; the rest must not leak into the model
		d = (512'(dat) << {a[5:0], 3'h0}) & spread(be);
		e = '{2'd0, a[31:6], d, be, mt, 1'b1};
		if (k == stream_store_packed_single && a[3:0] != 4'h0) begin
			expq.push_back('{2'd3, '0, '0, '0, mt, 1'b0});
		end else if (mt == uncacheable_type || mt == write_protect_type) begin
			expq.push_back(e);
		end else if (l1 && mixed_policy) begin
			e.ev = 2'd1;
			e.mtc = 0;
			expq.push_back(e);
		end else if (l1 || l2) begin
			expq.push_back('{2'd2, a[31:6], '0, '0, mt, 1'b0});
			expq.push_back('{2'd0, a[31:6], (h & ~spread(be)) | d, '1, mt, 1'b0});
		end else begin
			if (cv && cl != a[31:6]) drain();
			if (!cv) cm = mt;
			cl = a[31:6];
			cv = 1;
			cd = (cd & ~spread(be)) | d;
			cb |= be;
			if (&cb) drain();
		end
		st_valid <= 1;
		st_addr <= a;
		st_data <= dat;
		st_mask <= m;
		st_kind <= k;
		st_mtype <= mt;
		st_l1_hit <= l1;
		st_l2_hit <= l2;
		hit_line_data <= h;
		do @(posedge clock); while (!take_n);
		st_valid <= 0;
		@(posedge clock);
	endtask

	task automatic fence();
		if (cv) drain();
		fence_req <= 1;
		do @(posedge clock); while (!ack_n);
		fence_req <= 0;
		@(posedge clock);
	endtask

	task automatic stop_test();
		if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		#200000;
		errors++;
		stop_test();
	end

	initial begin
		{rst_n, st_valid, st_l1_hit, st_l2_hit, mixed_policy, fence_req, stall} = '0;
		{st_addr, st_data, st_mask, hit_line_data, errors, tests_run, cv, cl, cd, cb} = '0;
		{take_n, ack_n} = '0;
		st_kind = stream_store_integer;
		st_mtype = write_combining_type;
		cm = write_combining_type;
		seed = 86;
		repeat (12) @(posedge clock);
		rst_n <= 1;
		repeat (4) @(posedge clock);
		// full line, offset 0 written twice, first store sets bus type
		store(32'h1000, stream_store_double_quadword, write_through_type, 0, 0);
		store(32'h1000, stream_store_packed_double, write_combining_type, 0, 0);
		store(32'h1010, stream_store_packed_single, write_back_type, 0, 0);
		store(32'h1020, stream_store_double_quadword, write_combining_type, 0, 0);
		store(32'h1030, stream_store_double_quadword, write_combining_type, 0, 0);
		// partial lines: a new line forces a drain, then a fence
		store(32'h2008, stream_store_quadword, write_combining_type, 0, 0);
		store(32'h2004, stream_store_integer, write_back_type, 0, 0);
		store(32'h3010, masked_stream_store_128, write_combining_type, 0, 0);
		store(32'h3008, masked_stream_store_64, write_back_type, 0, 0);
		fence();
		store(32'h4024, stream_store_integer, uncacheable_type, 0, 0);
		store(32'h4048, stream_store_quadword, write_protect_type, 0, 0);
		store(32'h5008, stream_store_packed_single, write_combining_type, 0, 0);
		// cached hits, both policies
		mixed_policy <= 1;
		// let the strap settle so the bench model reads the new policy
		@(posedge clock);
		store(32'h6010, stream_store_double_quadword, write_back_type, 1, 0);
		// write-combining mapping keeps the target out of the caches
		store(32'h6050, stream_store_quadword, write_combining_type, 0, 0);
		fence();
		store(32'h7010, stream_store_quadword, write_through_type, 0, 1);
		mixed_policy <= 0;
		@(posedge clock);
		store(32'h8000, stream_store_double_quadword, write_back_type, 1, 0);
		// random misses over two lines
		for (int i = 0; i < 24; i++)
			store({20'h9, 6'($random(seed) & 1), 2'($random(seed)), 4'h0},
				nts_kind_t'(($random(seed) & 32'hffff) % 7),
				nts_mtype_t'(($random(seed) & 32'hffff) % 5), 0, 0);
		fence();
		repeat (5) @(posedge clock);
		check(expq.size(), 0);
		stop_test();
	end
endmodule // nts_store_combine_tb
`default_nettype wire
